// *** sfps_checker.sv ***
// Port assertions for the flash command engine
module sfps_checker #(
    parameter AW = 20
) (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Serial pins
    input logic chip_sel_n,
    input logic serial_clk,
    input logic serial_lane_zero_oe_r,
    input logic serial_lane_one_out_r,
    input logic serial_lane_one_oe_r,
    // Array port and status
    input logic [7:0] protect_bits,
    input logic [AW-1:0] array_addr_r,
    input logic array_prog_r,
    input logic array_erase_r,
    input logic [1:0] array_erase_kind_r,
    input logic busy_r,
    input logic write_enable_latch_r
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_start_needs_wel: assert property (
        $rose(busy_r) |-> write_enable_latch_r || $past(write_enable_latch_r))
        else $error("busy rose without write enable latch");
    a_start_after_sel: assert property (
        $rose(busy_r) |-> chip_sel_n) else $error("busy rose while selected");
    a_done_clears_wel: assert property (
        $fell(busy_r) |-> ##[0:1] !write_enable_latch_r)
        else $error("latch still set after completion");
    a_write_while_busy: assert property (
        array_prog_r || array_erase_r |-> ##[0:1] busy_r)
        else $error("array write outside busy");
    a_erase_aligned: assert property (
        array_erase_r |-> array_erase_kind_r == 2'h0 && array_addr_r[11:0] == 12'h000
        || array_erase_kind_r == 2'h1 && array_addr_r[15:0] == 16'h0000
        || array_erase_kind_r == 2'h2) else $error("erase kind or alignment wrong");
    a_chip_unprotected: assert property (
        array_erase_r && array_erase_kind_r == 2'h2 |-> protect_bits[4:2] == 3'h0)
        else $error("chip erase while protected");
    a_oe_release: assert property (
        $rose(chip_sel_n) |-> ##[1:8] !serial_lane_zero_oe_r && !serial_lane_one_oe_r)
        else $error("lanes still driven after deselect");
    a_drive_in_frame: assert property (
        $rose(serial_lane_one_oe_r) || $rose(serial_lane_zero_oe_r) |-> !chip_sel_n)
        else $error("lane driven while deselected");
    a_dual_lanes: assert property (
        $rose(serial_lane_zero_oe_r) |-> serial_lane_one_oe_r)
        else $error("lane zero driven alone");
    a_out_on_fall: assert property (
        $changed(serial_lane_one_out_r) && serial_lane_one_oe_r && $past(serial_lane_one_oe_r)
        |-> !$past(serial_clk, 2)) else $error("output changed in high clock phase");
endmodule // sfps_checker

bind sfps_engine sfps_checker #(.AW(AW)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_lane_zero_oe_r(serial_lane_zero_oe_r),
    .serial_lane_one_out_r(serial_lane_one_out_r),
    .serial_lane_one_oe_r(serial_lane_one_oe_r), .protect_bits(protect_bits),
    .array_addr_r(array_addr_r), .array_prog_r(array_prog_r), .array_erase_r(array_erase_r),
    .array_erase_kind_r(array_erase_kind_r), .busy_r(busy_r),
    .write_enable_latch_r(write_enable_latch_r));

// *** sfps_engine.v ***
// SPI flash command engine: reads, page program, erases, status read
// What this block does
// - 0BH: opcode, address, dummy, then data
// - Read address increments, wraps to zero
// - 3BH: data out, odd lane one
// - BBH: address and dummy on two lanes
// - Dummy values ignored; host releases lanes
// - Dual input pairs sampled same rising edge
// - 02H: program starts at select rise
// - Partial final byte discarded
// - Only last 256 bytes kept
// - Page index wraps within the page
// - Protected targets ignored silently
// - 20H/D7H erase 4-Kbyte sector
// - D8H erases 64-Kbyte block
// - 60H/C7H chip erase unless protected
// - Erase launched by select rise
// - No write without write enable latch
// - Status read accepted while busy
// - Status byte repeats until select rise
// - Decode from select fall, MSB first
// - Early select rise abandons instruction
// - Write enable latch cleared on completion
`include "sfps_map.vh"
module sfps_engine #(
    parameter AW = 20,
    parameter PP_CYC = `SFPS_PP_TIME_US * `SFPS_CLK_MHZ,
    parameter SE_CYC = `SFPS_SE_TIME_US * `SFPS_CLK_MHZ,
    parameter BE_CYC = `SFPS_BE_TIME_US * `SFPS_CLK_MHZ,
    parameter CE_CYC = `SFPS_CE_TIME_US * `SFPS_CLK_MHZ
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Serial pins
    input wire chip_sel_n,
    input wire serial_clk,
    input wire serial_lane_zero_in,
    input wire serial_lane_one_in,
    output reg serial_lane_zero_out_r,
    output reg serial_lane_zero_oe_r,
    output reg serial_lane_one_out_r,
    output reg serial_lane_one_oe_r,
    // Protection and array port
    input wire [7:0] protect_bits,
    input wire [7:0] array_rdata,
    output reg [AW-1:0] array_addr_r,
    output reg [7:0] array_wdata_r,
    output reg array_prog_r,
    output reg array_erase_r,
    output reg [1:0] array_erase_kind_r,
    // Status
    output reg busy_r,
    output reg write_enable_latch_r
);
    ////////////////////////////////////////////////////////////////
    localparam S_OPC = 3'd0;
    localparam S_ADR = 3'd1;
    localparam S_DUM = 3'd2;
    localparam S_RD = 3'd3;
    localparam S_PDAT = 3'd4;
    localparam S_STAT = 3'd5;
    localparam S_IGN = 3'd6;
    localparam K_SECT = 2'd0;
    localparam K_BLK = 2'd1;
    localparam K_CHIP = 2'd2;
    localparam E_IDLE = 2'd0;
    localparam E_PROG = 2'd1;
    localparam E_ERASE = 2'd2;

    // Protected region decode, top or bottom fraction of the array
    function prot_hit;
        input [AW-1:0] a;
        input [7:0] pb;
        reg [3:0] lvl;
        reg [AW-1:0] lo;
        begin
            lvl = pb[5:2];
            lo = {AW{1'b0}};
            prot_hit = 1'b0;
            case (lvl[2:0])
                3'd1: lo = {4'hF, {(AW-4){1'b0}}};
                3'd2: lo = {4'hE, {(AW-4){1'b0}}};
                3'd3: lo = {4'hC, {(AW-4){1'b0}}};
                3'd4: lo = {4'h8, {(AW-4){1'b0}}};
                default: lo = {AW{1'b0}};
            endcase
            if (lvl[2:0] == 3'd0) begin
                prot_hit = 1'b0;
            end else if (lvl[2:0] >= 3'd5) begin
                prot_hit = 1'b1;
            end else if (!lvl[3]) begin
                prot_hit = (a >= lo);
            end else begin
                prot_hit = (a <= ~lo);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    wire [3:0] pins;
    sfps_pin_sync #(.W(4)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin({chip_sel_n, serial_clk, serial_lane_one_in, serial_lane_zero_in}),
        .rst_val(4'h8),
        .level_r(pins)
    );
    reg sck_q_r;
    reg cs_q_r;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end else begin
            sck_q_r <= pins[2];
            cs_q_r <= pins[3];
        end
    end
    wire cs_n = pins[3];
    wire sck_rise = pins[2] & ~sck_q_r & ~cs_n;
    wire sck_fall = ~pins[2] & sck_q_r & ~cs_n;
    wire cs_rise = cs_n & ~cs_q_r;

    ////////////////////////////////////////////////////////////////
    reg [2:0] st_r;
    reg [7:0] opc_r;
    reg [7:0] sh_r;
    reg [4:0] cnt_r;
    reg [AW-1:0] addr_r;
    reg dual_in_r;
    reg dual_out_r;
    reg [7:0] dout_r;
    reg [7:0] page_mem [0:255];
    reg [255:0] page_vld_r;
    reg [7:0] pidx_r;
    reg pend_prog_r;
    reg pend_erase_r;
    reg [1:0] pend_kind_r;
    reg [1:0] ex_r;
    reg [31:0] tmr_r;
    reg [8:0] pcnt_r;
    wire [7:0] status_byte = {6'h00, write_enable_latch_r, busy_r};
    wire [4:0] last_cnt = dual_in_r ? 5'd3 : 5'd7;
    wire [7:0] sh_nxt = dual_in_r ? {sh_r[5:0], pins[1], pins[0]} : {sh_r[6:0], pins[0]};
    wire is_read = (opc_r == `SFPS_OP_READ_HS) || (opc_r == `SFPS_OP_READ_DO)
        || (opc_r == `SFPS_OP_READ_DIO);
    wire [7:0] opc_nxt = {sh_r[6:0], pins[0]};

    // Serial frame decode and shifting
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= S_OPC;
            opc_r <= 8'h00;
            sh_r <= 8'h00;
            cnt_r <= 5'd0;
            addr_r <= {AW{1'b0}};
            dual_in_r <= 1'b0;
            dual_out_r <= 1'b0;
            pidx_r <= 8'h00;
            page_vld_r <= {256{1'b0}};
            pend_prog_r <= 1'b0;
            pend_erase_r <= 1'b0;
            pend_kind_r <= K_SECT;
        end else if (cs_n) begin
            st_r <= S_OPC;
            cnt_r <= 5'd0;
            dual_in_r <= 1'b0;
            dual_out_r <= 1'b0;
            pend_prog_r <= 1'b0;
            pend_erase_r <= 1'b0;
        end else if (sck_rise) begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_r + 5'd1;
            case (st_r)
                S_OPC: begin
                    if (cnt_r == 5'd7) begin
                        opc_r <= opc_nxt;
                        cnt_r <= 5'd0;
                        st_r <= S_IGN;
                        if (opc_nxt == `SFPS_OP_READ_HS || opc_nxt == `SFPS_OP_READ_DO) begin
                            st_r <= S_ADR;
                        end else if (opc_nxt == `SFPS_OP_READ_DIO) begin
                            st_r <= S_ADR;
                            dual_in_r <= 1'b1;
                        end else if (opc_nxt == `SFPS_OP_STATUS_READ_COMMAND) begin
                            st_r <= S_STAT;
                        end else if (opc_nxt == `SFPS_OP_PROG || opc_nxt == `SFPS_OP_SE_A
                            || opc_nxt == `SFPS_OP_SE_B || opc_nxt == `SFPS_OP_BE) begin
                            st_r <= S_ADR;
                        end else if ((opc_nxt == `SFPS_OP_CE_A || opc_nxt == `SFPS_OP_CE_B)
                            && protect_bits[4:2] == 3'd0) begin
                            pend_erase_r <= 1'b1;
                            pend_kind_r <= K_CHIP;
                        end else if (opc_nxt == `SFPS_OP_WRITE_ENABLE_COMMAND || opc_nxt == `SFPS_OP_WRDI) begin
                            pend_prog_r <= 1'b0;
                        end
                    end
                end
                S_ADR: begin
                    addr_r <= dual_in_r ? {addr_r[AW-3:0], pins[1], pins[0]}
                        : {addr_r[AW-2:0], pins[0]};
                    if (cnt_r == (dual_in_r ? 5'd11 : 5'd23)) begin
                        cnt_r <= 5'd0;
                        if (is_read) begin
                            st_r <= S_DUM;
                        end else if (opc_r == `SFPS_OP_PROG) begin
                            st_r <= S_PDAT;
                            pidx_r <= {addr_r[6:0], pins[0]};
                            page_vld_r <= {256{1'b0}};
                        end else begin
                            st_r <= S_IGN;
                            pend_erase_r <= 1'b1;
                            pend_kind_r <= (opc_r == `SFPS_OP_BE) ? K_BLK : K_SECT;
                        end
                    end
                end
                S_DUM: begin
                    if (cnt_r == last_cnt) begin
                        cnt_r <= 5'd0;
                        st_r <= S_RD;
                        dual_out_r <= (opc_r != `SFPS_OP_READ_HS);
                    end
                end
                S_PDAT: begin
                    if (cnt_r == 5'd7) begin
                        cnt_r <= 5'd0;
                        page_mem[pidx_r] <= opc_nxt;
                        page_vld_r[pidx_r] <= 1'b1;
                        pidx_r <= pidx_r + 8'h01;
                        pend_prog_r <= 1'b1;
                    end
                end
                S_STAT: begin
                    if (cnt_r == 5'd7) begin
                        cnt_r <= 5'd0;
                    end
                end
                S_RD: begin
                    if (cnt_r == (dual_out_r ? 5'd3 : 5'd7)) begin
                        cnt_r <= 5'd0;
                        addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    cnt_r <= 5'd0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Output shifting on falling edges
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_r <= 8'h00;
            serial_lane_zero_out_r <= 1'b0;
            serial_lane_one_out_r <= 1'b0;
            serial_lane_zero_oe_r <= 1'b0;
            serial_lane_one_oe_r <= 1'b0;
        end else if (cs_n) begin
            serial_lane_zero_oe_r <= 1'b0;
            serial_lane_one_oe_r <= 1'b0;
        end else if (sck_fall && (st_r == S_RD || st_r == S_STAT)) begin
            if (cnt_r == 5'd0) begin
                dout_r <= (st_r == S_STAT) ? status_byte : array_rdata;
                if (dual_out_r) begin
                    serial_lane_one_out_r <= (st_r == S_STAT) ? status_byte[7] : array_rdata[7];
                    serial_lane_zero_out_r <= (st_r == S_STAT) ? status_byte[6] : array_rdata[6];
                end else begin
                    serial_lane_one_out_r <= (st_r == S_STAT) ? status_byte[7] : array_rdata[7];
                end
            end else if (dual_out_r) begin
                serial_lane_one_out_r <= dout_r[7 - {cnt_r[1:0], 1'b0}];
                serial_lane_zero_out_r <= dout_r[6 - {cnt_r[1:0], 1'b0}];
            end else begin
                serial_lane_one_out_r <= dout_r[3'd7 - cnt_r[2:0]];
            end
            serial_lane_one_oe_r <= 1'b1;
            serial_lane_zero_oe_r <= dual_out_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Self-timed program and erase
    wire [AW-1:0] page_base = {addr_r[AW-1:8], 8'h00};
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ex_r <= E_IDLE;
            tmr_r <= 32'd0;
            pcnt_r <= 9'd0;
            busy_r <= 1'b0;
            write_enable_latch_r <= 1'b0;
            array_addr_r <= {AW{1'b0}};
            array_wdata_r <= 8'hFF;
            array_prog_r <= 1'b0;
            array_erase_r <= 1'b0;
            array_erase_kind_r <= K_SECT;
        end else begin
            array_prog_r <= 1'b0;
            array_erase_r <= 1'b0;
            if (!busy_r) begin
                array_addr_r <= addr_r;
            end
            case (ex_r)
                E_IDLE: begin
                    if (cs_rise && !busy_r && opc_r == `SFPS_OP_WRITE_ENABLE_COMMAND && st_r == S_IGN) begin
                        write_enable_latch_r <= 1'b1;
                    end else if (cs_rise && !busy_r && opc_r == `SFPS_OP_WRDI && st_r == S_IGN) begin
                        write_enable_latch_r <= 1'b0;
                    end else if (cs_rise && !busy_r && write_enable_latch_r) begin
                        if (pend_prog_r && !prot_hit(addr_r, protect_bits)) begin
                            ex_r <= E_PROG;
                            busy_r <= 1'b1;
                            pcnt_r <= 9'd0;
                            tmr_r <= PP_CYC;
                        end else if (pend_erase_r && (pend_kind_r == K_CHIP
                            || !prot_hit(addr_r, protect_bits))) begin
                            ex_r <= E_ERASE;
                            busy_r <= 1'b1;
                            array_erase_r <= 1'b1;
                            array_erase_kind_r <= pend_kind_r;
                            if (pend_kind_r == K_SECT) begin
                                array_addr_r <= {addr_r[AW-1:`SFPS_SECTOR_LSB],
                                    {`SFPS_SECTOR_LSB{1'b0}}};
                                tmr_r <= SE_CYC;
                            end else if (pend_kind_r == K_BLK) begin
                                array_addr_r <= {addr_r[AW-1:`SFPS_BLOCK_LSB],
                                    {`SFPS_BLOCK_LSB{1'b0}}};
                                tmr_r <= BE_CYC;
                            end else begin
                                array_addr_r <= {AW{1'b0}};
                                tmr_r <= CE_CYC;
                            end
                        end
                    end
                end
                E_PROG: begin
                    if (pcnt_r < 9'd256) begin
                        pcnt_r <= pcnt_r + 9'd1;
                        if (page_vld_r[pcnt_r[7:0]]) begin
                            array_prog_r <= 1'b1;
                            array_addr_r <= page_base | {{(AW-8){1'b0}}, pcnt_r[7:0]};
                            array_wdata_r <= page_mem[pcnt_r[7:0]];
                        end
                    end
                    if (tmr_r <= 32'd1) begin
                        ex_r <= E_IDLE;
                        busy_r <= 1'b0;
                        write_enable_latch_r <= 1'b0;
                    end else begin
                        tmr_r <= tmr_r - 32'd1;
                    end
                end
                default: begin
                    if (tmr_r <= 32'd1) begin
                        ex_r <= E_IDLE;
                        busy_r <= 1'b0;
                        write_enable_latch_r <= 1'b0;
                    end else begin
                        tmr_r <= tmr_r - 32'd1;
                    end
                end
            endcase
        end
    end
endmodule // sfps_engine

// *** sfps_host_model.sv ***
// Host SPI controller model: select, serial clock and both lanes
module sfps_host_model (
    // Clock for idle lane pattern
    input logic clk,
    // Pins toward the device
    output logic chip_sel_n,
    output logic serial_clk,
    output logic lz_in,
    output logic lo_in,
    // Device lane drive
    input logic lz_out,
    input logic lz_oe,
    input logic lo_out,
    input logic lo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] hd = 2'h0;
    logic [1:0] hoe = 2'h0;
    logic pat = 1'b0;
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
    end
    // Undriven lanes toggle so stale values never pass
    always @(posedge clk) pat <= ~pat;
    assign lz_in = lz_oe ? lz_out : hoe[0] ? hd[0] : pat;
    assign lo_in = lo_oe ? lo_out : hoe[1] ? hd[1] : ~pat;
    ////////////////////////////////////////////////////////////////
    // One serial clock, data set in low phase, sampled at rise
    task automatic clk2(input logic [1:0] d, input logic [1:0] oe, output logic [1:0] q);
        hd = d;
        hoe = oe;
        #62.5;
        q = {lo_in, lz_in};
        serial_clk = 1'b1;
        #62.5;
        serial_clk = 1'b0;
    endtask
    task automatic sel();
        chip_sel_n = 1'b0;
        #100;
    endtask
    task automatic desel();
        hoe = 2'h0;
        #100;
        chip_sel_n = 1'b1;
        #300;
    endtask
    // Lane zero byte; rel frees the lane before the first data fall
    task automatic tx8(input logic [7:0] b, input logic rel = 1'b0);
        logic [1:0] q;
        for (int i = 7; i >= 0; i--) clk2({1'b0, b[i]}, {1'b0, !(rel && i == 0)}, q);
    endtask
    task automatic rx8(output logic [7:0] b);
        logic [1:0] q;
        for (int i = 7; i >= 0; i--) begin
            clk2(2'h0, 2'h0, q);
            b[i] = q[1];
        end
    endtask
    // Two bits a clock, odd bit on lane one
    task automatic dual8(input logic [7:0] b, input logic [1:0] oe, output logic [7:0] r);
        logic [1:0] q;
        for (int i = 6; i >= 0; i -= 2) begin
            clk2(b[i+:2], oe, q);
            r[i+:2] = q;
        end
    endtask
endmodule // sfps_host_model

// *** sfps_map.vh ***
// Opcodes, field positions and timing constants of the flash command engine
`ifndef SFPS_MAP_VH
`define SFPS_MAP_VH
`define SFPS_OP_READ_HS 8'h0B
`define SFPS_OP_READ_DO 8'h3B
`define SFPS_OP_READ_DIO 8'hBB
`define SFPS_OP_PROG 8'h02
`define SFPS_OP_SE_A 8'h20
`define SFPS_OP_SE_B 8'hD7
`define SFPS_OP_BE 8'hD8
`define SFPS_OP_CE_A 8'h60
`define SFPS_OP_CE_B 8'hC7
`define SFPS_OP_STATUS_READ_COMMAND 8'h05
`define SFPS_OP_WRITE_ENABLE_COMMAND 8'h06
`define SFPS_OP_WRDI 8'h04
`define SFPS_ADDR_W 24
`define SFPS_PAGE_BYTES 256
`define SFPS_SECTOR_LSB 12
`define SFPS_BLOCK_LSB 16
`define SFPS_ST_BUSY 0
`define SFPS_ST_WEL 1
`define SFPS_CLK_MHZ 100
`define SFPS_PP_TIME_US 800
`define SFPS_SE_TIME_US 40000
`define SFPS_BE_TIME_US 80000
`define SFPS_CE_TIME_US 500000
`endif

// *** sfps_pin_sync.v ***
// Three-flop pin synchroniser with agreement filter
module sfps_pin_sync #(
    parameter W = 4
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Pins and filtered levels
    input wire [W-1:0] pin,
    input wire [W-1:0] rst_val,
    output reg [W-1:0] level_r
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // Change counts only once stages two and three agree
    reg init_r;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_r <= {W{1'b0}};
            init_r <= 1'b0;
        end else if (!init_r) begin
            level_r <= rst_val;
            init_r <= 1'b1;
        end else begin
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // sfps_pin_sync

// *** tb_top.sv ***
// Self-checking bench for the flash command engine
`include "sfps_map.vh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("CHECK FAILED at %0t got %h expected %h", $time, g, e); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] protect_bits = 8'h00;
    logic chip_sel_n, serial_clk, lz_in, lo_in, lz_out, lz_oe, lo_out, lo_oe;
    logic array_prog, array_erase, busy, write_enable_latch;
    logic [1:0] kind;
    logic [1:0] q;
    logic [19:0] array_addr;
    logic [7:0] array_wdata, array_rdata, s1, s2, r;
    logic [7:0] mem [0:20'hFFFFF];
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    initial forever #5 clk = ~clk;
    sfps_engine #(.PP_CYC(600), .SE_CYC(600), .BE_CYC(600), .CE_CYC(600)) DUT (
        .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .serial_lane_zero_in(lz_in), .serial_lane_one_in(lo_in),
        .serial_lane_zero_out_r(lz_out), .serial_lane_zero_oe_r(lz_oe),
        .serial_lane_one_out_r(lo_out), .serial_lane_one_oe_r(lo_oe),
        .protect_bits(protect_bits), .array_rdata(array_rdata), .array_addr_r(array_addr),
        .array_wdata_r(array_wdata), .array_prog_r(array_prog), .array_erase_r(array_erase),
        .array_erase_kind_r(kind), .busy_r(busy), .write_enable_latch_r(write_enable_latch));
    sfps_host_model host (.clk(clk), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .lz_in(lz_in), .lo_in(lo_in), .lz_out(lz_out), .lz_oe(lz_oe), .lo_out(lo_out),
        .lo_oe(lo_oe));
    ////////////////////////////////////////////////////////////////
    // Array model: program only clears bits
    assign array_rdata = mem[array_addr];
    always @(posedge clk) begin
        if (array_prog) mem[array_addr] = mem[array_addr] & array_wdata;
        if (array_erase) for (int i = 0; i < 32'h100000; i++)
            if (kind == 2'h2 || i[19:16] == array_addr[19:16]
                && (kind == 2'h1 || i[15:12] == array_addr[15:12])) mem[i] = 8'hFF;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic cmd(input logic [7:0] op);
        host.sel();
        host.tx8(op);
        host.desel();
    endtask
    task automatic hdr(input logic [7:0] op, input logic [23:0] a);
        host.sel();
        host.tx8(op);
        host.tx8(a[23:16]);
        host.tx8(a[15:8]);
        host.tx8(a[7:0]);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask
    task automatic t_abort();
        host.sel();
        for (int i = 7; i > 0; i--) host.clk2({1'b0, `SFPS_OP_WRITE_ENABLE_COMMAND >> i & 1'b1}, 2'h1, q);
        host.desel();
        `CHK(write_enable_latch, 1'b0)
        cmd(`SFPS_OP_WRITE_ENABLE_COMMAND);
        `CHK(write_enable_latch, 1'b1)
        cmd(`SFPS_OP_WRDI);
        `CHK(write_enable_latch, 1'b0)
    endtask
    task automatic t_reads();
        mem[20'hFFFFF] = 8'h5A;
        mem[20'h00000] = 8'hC3;
        mem[20'h12345] = 8'hB4;
        mem[20'h12346] = 8'h69;
        mem[20'h00100] = 8'hD2;
        hdr(`SFPS_OP_READ_HS, 24'h0FFFFF);
        host.tx8(8'hA5);
        host.rx8(s1);
        host.rx8(s2);
        host.desel();
        `CHK(s1, 8'h5A)
        `CHK(s2, 8'hC3)
        hdr(`SFPS_OP_READ_DO, 24'h012345);
        host.tx8(8'h00, 1'b1);
        host.dual8(8'h00, 2'h0, s1);
        host.dual8(8'h00, 2'h0, s2);
        host.desel();
        `CHK(s1, 8'hB4)
        `CHK(s2, 8'h69)
        host.sel();
        host.tx8(`SFPS_OP_READ_DIO);
        host.dual8(8'h00, 2'h3, r);
        host.dual8(8'h01, 2'h3, r);
        host.dual8(8'h00, 2'h3, r);
        for (int i = 0; i < 4; i++) host.clk2(2'h2, {2{i < 3}}, q);
        host.dual8(8'h00, 2'h0, s1);
        host.desel();
        `CHK(s1, 8'hD2)
    endtask
    task automatic t_prog();
        hdr(`SFPS_OP_PROG, 24'h0200FE);
        host.tx8(8'h11);
        host.desel();
        repeat (100) @(posedge clk);
        `CHK(busy, 1'b0)
        `CHK(mem[20'h200FE], 8'hFF)
        cmd(`SFPS_OP_WRITE_ENABLE_COMMAND);
        hdr(`SFPS_OP_PROG, 24'h0200FE);
        host.tx8(8'h11);
        host.tx8(8'h22);
        host.tx8(8'h33);
        for (int i = 0; i < 4; i++) host.clk2(2'h0, 2'h1, q);
        host.desel();
        host.sel();
        host.tx8(`SFPS_OP_STATUS_READ_COMMAND);
        host.rx8(s1);
        host.rx8(s2);
        host.desel();
        `CHK(s1, 8'h03)
        `CHK(s2, 8'h03)
        wait_idle();
        `CHK(write_enable_latch, 1'b0)
        `CHK(mem[20'h200FE], 8'h11)
        `CHK(mem[20'h200FF], 8'h22)
        `CHK(mem[20'h20000], 8'h33)
        `CHK(mem[20'h20001], 8'hFF)
        cmd(`SFPS_OP_WRITE_ENABLE_COMMAND);
        hdr(`SFPS_OP_PROG, 24'h030000);
        for (int i = 0; i < 258; i++) host.tx8(i < 256 ? {1'b1, i[6:0]} : 8'h3C);
        host.desel();
        wait_idle();
        `CHK(mem[20'h30000], 8'h3C)
        `CHK(mem[20'h30001], 8'h3C)
        `CHK(mem[20'h30002], 8'h82)
    endtask
    task automatic t_erase();
        logic [7:0] ops [5] = '{`SFPS_OP_SE_A, `SFPS_OP_SE_B, `SFPS_OP_BE,
            `SFPS_OP_CE_A, `SFPS_OP_CE_B};
        logic [19:0] at [5] = '{20'h23456, 20'h45678, 20'h34567, 20'h0, 20'h0};
        logic [19:0] ina [5] = '{20'h23000, 20'h45FFF, 20'h3FFFF, 20'h50000, 20'h60000};
        logic [19:0] outa [5] = '{20'h24000, 20'h44FFF, 20'h40000, 20'h1, 20'h2};
        for (int i = 0; i < 5; i++) begin
            mem[ina[i]] = 8'h00;
            mem[outa[i]] = 8'h00;
            cmd(`SFPS_OP_WRITE_ENABLE_COMMAND);
            hdr(ops[i], {4'h0, at[i]});
            if (i > 2) host.hoe = 2'h0;
            host.desel();
            wait_idle();
            `CHK(mem[ina[i]], 8'hFF)
            `CHK(mem[outa[i]], i < 3 ? 8'h00 : 8'hFF)
        end
        @(negedge clk);
        protect_bits = 8'h04;
        mem[20'hF1000] = 8'h00;
        for (int i = 0; i < 4; i += 3) begin
            cmd(`SFPS_OP_WRITE_ENABLE_COMMAND);
            hdr(ops[i], 24'h0F1000);
            host.desel();
            repeat (100) @(posedge clk);
            `CHK(busy, 1'b0)
            `CHK(mem[20'hF1000], 8'h00)
        end
        cmd(`SFPS_OP_WRDI);
        @(negedge clk);
        protect_bits = 8'h00;
    endtask
    initial begin
        for (int i = 0; i < 32'h100000; i++) mem[i] = 8'hFF;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk);
        t_abort();
        t_reads();
        t_prog();
        t_erase();
        give_verdict();
    end
endmodule // tb_top
